// file: hdl/ivcm_top.sv
// Interrupt vector mapping, wake logic and core/debug register map
`timescale 1ns/10ps
module ivcm_top
   import ivcm_pkg::*;
(
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_debug,
   output logic [DATA_W-1:0] reg_rdata,
   // Interrupt sources
   input wire logic top_level_pin_irq,
   input wire logic auto_wakeup_unit,
   input wire logic clk_ctrl_irq,
   input wire logic port_a_pin_change,
   input wire logic port_a_pin_one,
   input wire logic port_b_pin_change,
   input wire logic port_c_pin_change,
   input wire logic port_d_pin_change,
   input wire logic port_e_pin_change,
   input wire logic spi_done,
   input wire logic advanced_timer_update,
   input wire logic advanced_timer_cc,
   input wire logic general_timer_update,
   input wire logic general_timer_cc,
   input wire logic async_serial_port_tx,
   input wire logic async_serial_port_rx,
   input wire logic two_wire_irq,
   input wire logic converter_unit,
   input wire logic basic_timer,
   input wire logic flash_program_done,
   input wire logic flash_write_protect_hit,
   input wire logic trap_req,
   // Core side
   input wire logic halt_mode,
   input wire logic active_halt_mode,
   output logic wake_out,
   output logic vec_valid,
   output logic [VEC_W-1:0] vec_addr,
   output logic irq_out
);
   // ------------------------------------------------------------
   // Source numbering
   // ------------------------------------------------------------
   logic [NUM_IRQ-1:0] raw;

   always_comb begin
      raw = '0;
      raw[IRQ_TOP_PIN] = top_level_pin_irq;                       // [RULE_06]
      raw[IRQ_AWU] = auto_wakeup_unit;                            // [RULE_06]
      raw[IRQ_CLK] = clk_ctrl_irq;                                // [RULE_06]
      raw[IRQ_PORT_A] = port_a_pin_change;                        // [RULE_07]
      raw[IRQ_PORT_B] = port_b_pin_change;                        // [RULE_07]
      raw[IRQ_PORT_C] = port_c_pin_change;                        // [RULE_07]
      raw[IRQ_PORT_D] = port_d_pin_change;                        // [RULE_07]
      raw[IRQ_PORT_E] = port_e_pin_change;                        // [RULE_07]
      raw[IRQ_SPI] = spi_done;                                    // [RULE_08]
      raw[IRQ_ADV_UPD] = advanced_timer_update;                   // [RULE_08]
      raw[IRQ_ADV_CC] = advanced_timer_cc;                        // [RULE_08]
      raw[IRQ_GEN_UPD] = general_timer_update;                    // [RULE_08]
      raw[IRQ_GEN_CC] = general_timer_cc;                         // [RULE_08]
      raw[IRQ_UART_TX] = async_serial_port_tx;                    // [RULE_08]
      raw[IRQ_UART_RX] = async_serial_port_rx;                    // [RULE_08]
      raw[IRQ_TWO_WIRE] = two_wire_irq;                           // [RULE_08]
      raw[IRQ_CONV] = converter_unit;                             // [RULE_08]
      raw[IRQ_BASIC_TIM] = basic_timer;                           // [RULE_08]
      raw[IRQ_FLASH] = flash_program_done | flash_write_protect_hit; // [RULE_08]
      raw = raw & USED_MASK;                                      // [RULE_15]
   end

   // ------------------------------------------------------------
   // Register store
   // ------------------------------------------------------------
   logic [DATA_W-1:0] regs_q [NUM_REGS];
   logic [NUM_REGS-1:0] hit;
   logic [NUM_REGS-1:0] allowed;

   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : g_reg
         assign hit[g] = (reg_addr == REG_ADDR[g]);
         assign allowed[g] = !REG_DEBUG_ONLY[g] || reg_debug;     // [RULE_10]
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               regs_q[g] <= REG_RST[g];                           // [RULE_09] [RULE_11] [RULE_12] [RULE_13] [RULE_14]
            end else if (clk_en && reg_wr && hit[g] && allowed[g]) begin
               regs_q[g] <= reg_wdata;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Status and mask
   // ------------------------------------------------------------
   localparam int SW = STAT_BYTES * DATA_W;
   logic [NUM_IRQ-1:0] raw_prev_q;
   logic [SW-1:0] stat_q;
   logic [SW-1:0] stat_d;
   logic [SW-1:0] mask_q;
   logic [SW-1:0] stat_clr;
   logic [SW-1:0] stat_set;
   logic [ADDR_W-1:0] stat_off;
   logic [ADDR_W-1:0] mask_off;
   logic stat_hit;
   logic mask_hit;

   assign stat_off = reg_addr - STAT_ADDR;
   assign mask_off = reg_addr - MASK_ADDR;
   assign stat_hit = (reg_addr >= STAT_ADDR) && (stat_off < ADDR_W'(STAT_BYTES));
   assign mask_hit = (reg_addr >= MASK_ADDR) && (mask_off < ADDR_W'(STAT_BYTES));

   always_comb begin
      stat_clr = '0;
      if (reg_rd && stat_hit) begin
         stat_clr = SW'({DATA_W{1'b1}}) << (stat_off[1:0] * DATA_W);
      end
      stat_set = SW'(raw & ~raw_prev_q);
      stat_d = (stat_q & ~stat_clr) | stat_set;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         raw_prev_q <= '0;
         stat_q <= '0;
      end else if (clk_en) begin
         raw_prev_q <= raw;
         stat_q <= stat_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mask_q <= '0;
      end else if (clk_en && reg_wr && mask_hit) begin
         mask_q[mask_off[1:0]*DATA_W +: DATA_W] <= reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   logic [DATA_W-1:0] rd_d;

   always_comb begin
      rd_d = RD_IDLE;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (hit[i] && allowed[i]) begin
            rd_d = regs_q[i];                                     // [RULE_10]
         end
      end
      if (stat_hit) begin
         rd_d = stat_q[stat_off[1:0]*DATA_W +: DATA_W];
      end
      if (mask_hit) begin
         rd_d = mask_q[mask_off[1:0]*DATA_W +: DATA_W];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= RD_IDLE;
      end else if (clk_en) begin
         reg_rdata <= reg_rd ? rd_d : RD_IDLE;
      end
   end

   // ------------------------------------------------------------
   // Vector selection
   // ------------------------------------------------------------
   logic [NUM_IRQ-1:0] pend;
   logic found;
   logic [IDX_W-1:0] idx;
   logic boot_q;

   assign pend = stat_q[NUM_IRQ-1:0] & mask_q[NUM_IRQ-1:0];

   ivcm_vec_sel u_sel (
      .req(pend),
      .found(found),
      .idx(idx)
   );

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         boot_q <= 1'b1;
         vec_valid <= 1'b0;
         vec_addr <= VEC_RESET;
      end else if (clk_en) begin
         boot_q <= 1'b0;
         vec_valid <= boot_q || trap_req || found;
         if (boot_q) begin
            vec_addr <= VEC_RESET;                                // [RULE_01]
         end else if (trap_req) begin
            vec_addr <= VEC_TRAP;                                 // [RULE_01]
         end else if (found) begin
            vec_addr <= VEC_IRQ_BASE + (VEC_W'(idx) << VEC_SHIFT); // [RULE_01]
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_out <= 1'b0;
      end else if (clk_en) begin
         irq_out <= |pend;
      end
   end

   // ------------------------------------------------------------
   // Wake
   // ------------------------------------------------------------
   logic wake;

   ivcm_wake u_wake (
      .req(raw),
      .port_a_pin_one(port_a_pin_one),
      .halt_mode(halt_mode),
      .active_halt_mode(active_halt_mode),
      .wake(wake)
   );

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wake_out <= 1'b1;                                        // [RULE_03]
      end else if (clk_en) begin
         wake_out <= wake;                                        // [RULE_02] [RULE_04] [RULE_05]
      end
   end
endmodule

// file: hdl/ivcm_pkg.sv
// Constants, register map and source numbering for the interrupt vector and core map block
// How it works
// RULE_01: Reset vector 0x008000, trap 0x008004, request N at 0x008008 plus four N.
// RULE_02: Port A pin change wakes both halt states, unless it came from pin A1.
// RULE_03: Ports B-E, serial end of transfer, two-wire bus and reset wake both states.
// RULE_04: Auto-wakeup wakes only from active-halt, never from full halt.
// RULE_05: Top pin, clock, timers, serial tx/rx, converter, flash and trap never wake.
// RULE_06: Request 0 top-level pin, 1 auto-wakeup, 2 clock controller.
// RULE_07: Requests 3 to 7 are pin changes of ports A to E in order.
// RULE_08: Requests 10-14, 17-19, 22-24 carry the fixed peripheral sources listed.
// RULE_09: Eight priority registers from 0x7F70 upward, each resetting to 0xFF.
// RULE_10: Core register copies are reachable by debug accesses only.
// RULE_11: Core registers reset to zero, stack pointer 0x03FF, condition flags 0x28.
// RULE_12: Two breakpoint addresses, extended/high/low bytes, all reset to 0xFF.
// RULE_13: Debug status 1 resets 0x10, controls and status 2 0x00, enable 0xFF.
// RULE_14: Single-wire debug control at 0x7F80 and global config at 0x7F60, reset 0x00.
// RULE_15: Requests 8, 9, 15, 16, 20, 21 have no source and never assert.
package ivcm_pkg;
   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int NUM_IRQ = 25;
   localparam int IDX_W = 5;
   localparam int VEC_W = 24;

   // ------------------------------------------------------------
   // Vectors
   // ------------------------------------------------------------
   localparam logic [VEC_W-1:0] VEC_RESET = 24'h008000;
   localparam logic [VEC_W-1:0] VEC_TRAP = 24'h008004;
   localparam logic [VEC_W-1:0] VEC_IRQ_BASE = 24'h008008;
   localparam int VEC_SHIFT = 2;

   // ------------------------------------------------------------
   // Request numbers
   // ------------------------------------------------------------
   localparam int IRQ_TOP_PIN = 0;
   localparam int IRQ_AWU = 1;
   localparam int IRQ_CLK = 2;
   localparam int IRQ_PORT_A = 3;
   localparam int IRQ_PORT_B = 4;
   localparam int IRQ_PORT_C = 5;
   localparam int IRQ_PORT_D = 6;
   localparam int IRQ_PORT_E = 7;
   localparam int IRQ_SPI = 10;
   localparam int IRQ_ADV_UPD = 11;
   localparam int IRQ_ADV_CC = 12;
   localparam int IRQ_GEN_UPD = 13;
   localparam int IRQ_GEN_CC = 14;
   localparam int IRQ_UART_TX = 17;
   localparam int IRQ_UART_RX = 18;
   localparam int IRQ_TWO_WIRE = 19;
   localparam int IRQ_CONV = 22;
   localparam int IRQ_BASIC_TIM = 23;
   localparam int IRQ_FLASH = 24;

   // ------------------------------------------------------------
   // Wake and source masks
   // ------------------------------------------------------------
   localparam logic [NUM_IRQ-1:0] HALT_WAKE_MASK = 25'h00804f8;
   localparam logic [NUM_IRQ-1:0] AHALT_WAKE_MASK = 25'h00804fa;
   localparam logic [NUM_IRQ-1:0] USED_MASK = 25'h1ce7cff;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int NUM_REGS = 32;
   localparam logic [ADDR_W-1:0] REG_ADDR [NUM_REGS] = '{
      16'h7f00, 16'h7f01, 16'h7f02, 16'h7f03, 16'h7f04, 16'h7f05, 16'h7f06, 16'h7f07,
      16'h7f08, 16'h7f09, 16'h7f0a, 16'h7f60,
      16'h7f70, 16'h7f71, 16'h7f72, 16'h7f73, 16'h7f74, 16'h7f75, 16'h7f76, 16'h7f77,
      16'h7f80,
      16'h7f90, 16'h7f91, 16'h7f92, 16'h7f93, 16'h7f94, 16'h7f95,
      16'h7f96, 16'h7f97, 16'h7f98, 16'h7f99, 16'h7f9a};
   localparam logic [DATA_W-1:0] REG_RST [NUM_REGS] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h03, 8'hff, 8'h28, 8'h00,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'h00,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'h00, 8'h00, 8'h10, 8'h00, 8'hff};
   localparam logic [NUM_REGS-1:0] REG_DEBUG_ONLY = 32'h000007ff;

   localparam int STAT_BYTES = 4;
   localparam logic [ADDR_W-1:0] STAT_ADDR = 16'h7fa0;
   localparam logic [ADDR_W-1:0] MASK_ADDR = 16'h7fa4;
   localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;
endpackage

// file: hdl/ivcm_vec_sel.sv
// Lowest-numbered request finder
`timescale 1ns/10ps
module ivcm_vec_sel
   import ivcm_pkg::*;
(
   // Requests
   input wire logic [NUM_IRQ-1:0] req,
   // Result
   output logic found,
   output logic [IDX_W-1:0] idx
);
   always_comb begin
      found = 1'b0;
      idx = '0;
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
         if (req[i]) begin
            found = 1'b1;
            idx = IDX_W'(i);
         end
      end
   end
endmodule

// file: hdl/ivcm_wake.sv
// Wake decision for halt and active-halt
`timescale 1ns/10ps
module ivcm_wake
   import ivcm_pkg::*;
(
   // Requests and qualifiers
   input wire logic [NUM_IRQ-1:0] req,
   input wire logic port_a_pin_one,
   // Low-power state
   input wire logic halt_mode,
   input wire logic active_halt_mode,
   // Result
   output logic wake
);
   logic [NUM_IRQ-1:0] qual;

   always_comb begin
      qual = req;
      if (port_a_pin_one) begin
         qual[IRQ_PORT_A] = 1'b0;                                 // [RULE_02]
      end
      wake = (halt_mode && |(qual & HALT_WAKE_MASK)) ||           // [RULE_03] [RULE_05]
             (active_halt_mode && |(qual & AHALT_WAKE_MASK));     // [RULE_04]
   end
endmodule

// file: tb/ivcm_top_monitor.sv
// Port checker for the interrupt vector and core map block
`timescale 1ns/10ps
module ivcm_top_monitor
   import ivcm_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_debug,
   input wire logic [DATA_W-1:0] reg_rdata,
   // Sources and core side
   input wire logic auto_wakeup_unit,
   input wire logic port_b_pin_change,
   input wire logic trap_req,
   input wire logic halt_mode,
   input wire logic active_halt_mode,
   input wire logic wake_out,
   input wire logic vec_valid,
   input wire logic [VEC_W-1:0] vec_addr,
   input wire logic irq_out
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   a_boot_vector: assert property ($fell(rst) |=> vec_valid && vec_addr == 24'h008000)
      else $error("boot vector missing");
   a_trap_vector: assert property (clk_en && trap_req |=> vec_valid && vec_addr == 24'h008004)
      else $error("trap vector wrong");
   a_vector_slot: assert property (vec_valid |-> vec_addr[1:0] == 2'b00 && vec_addr <= 24'h008068
      && vec_addr >= 24'h008000 && !(vec_addr inside {24'h008028, 24'h00802c, 24'h008044,
      24'h008048, 24'h008058, 24'h00805c})) else $error("vector outside table");
   a_core_hidden: assert property (clk_en && reg_rd && !reg_debug
      && reg_addr inside {[16'h7f00:16'h7f0a]} |=> reg_rdata == 8'h00) else $error("core copy visible");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside slot");
   a_no_mode_wake: assert property (!rst && clk_en && !halt_mode && !active_halt_mode |=> !wake_out)
      else $error("wake without halt");
   a_port_wake: assert property (clk_en && halt_mode && port_b_pin_change |=> wake_out)
      else $error("port b no wake");
   a_awu_wake: assert property (clk_en && active_halt_mode && auto_wakeup_unit |=> wake_out)
      else $error("auto wakeup no wake");
   a_irq_vector: assert property ($rose(irq_out) && !$past(trap_req)
      |-> vec_valid && vec_addr >= 24'h008008) else $error("irq without vector");
endmodule

bind ivcm_top ivcm_top_monitor mon (.*);

// file: tb/ivcm_src_model.sv
// Peripheral source model driving request lines
`timescale 1ns/10ps
module ivcm_src_model
   import ivcm_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Command
   input wire logic [NUM_IRQ-1:0] lvl,
   // Source lines
   output logic [NUM_IRQ-1:0] src_q
);
   // Reserved slots have no source
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         src_q <= '0;
      end else begin
         src_q <= lvl & ~25'h0318300;
      end
   end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the interrupt vector and core map block
`timescale 1ns/10ps
module tb_top;
   import ivcm_pkg::*;
   logic sys_clk = 0, rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, reg_debug = 1;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, d;
   logic halt_mode = 0, active_halt_mode = 0, port_a_pin_one = 0, trap_req = 0;
   logic flash_write_protect_hit = 0, wake_out, vec_valid, irq_out, e;
   logic [VEC_W-1:0] vec_addr;
   logic [NUM_IRQ-1:0] lvl = '0, src;
   logic [31:0] seed = 32'h54, n;
   logic [31:0] corner [5] = '{32'h02000002, 32'h0a000008, 32'h04000008, 32'h06000001, 32'h07c67805};
   int miscompares = 0, total_checks = 0, i, k, b;

   initial forever #12.5 sys_clk = ~sys_clk;

   ivcm_src_model src_m (.sys_clk(sys_clk), .rst(rst), .lvl(lvl), .src_q(src));
   ivcm_top dut (.*, .top_level_pin_irq(src[0]), .auto_wakeup_unit(src[1]), .clk_ctrl_irq(src[2]),
      .port_a_pin_change(src[3]), .port_b_pin_change(src[4]), .port_c_pin_change(src[5]),
      .port_d_pin_change(src[6]), .port_e_pin_change(src[7]), .spi_done(src[10]),
      .advanced_timer_update(src[11]), .advanced_timer_cc(src[12]), .general_timer_update(src[13]),
      .general_timer_cc(src[14]), .async_serial_port_tx(src[17]), .async_serial_port_rx(src[18]),
      .two_wire_irq(src[19]), .converter_unit(src[22]), .basic_timer(src[23]), .flash_program_done(src[24]));

   // ----------------------------------------
   // Expectations
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic exp_wake(logic [NUM_IRQ-1:0] s, logic h, logic ah, logic p1);
      logic [NUM_IRQ-1:0] w;
      w = s & 25'h00804f8;
      if (p1) w[3] = 1'b0;
      return (h && |w) || (ah && (|w || s[1]));
   endfunction

   function automatic logic rsv(int x);
      return x inside {8, 9, 15, 16, 20, 21};
   endfunction

   // ----------------------------------------
   // Bus and report tasks
   // ----------------------------------------
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
      total_checks++;
      if (s !== ex) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, ex, s);
      end
   endtask

   task automatic finish_test();
      if (miscompares == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge sys_clk);
      chk("reset wake", 1, wake_out);
      rst <= 1'b0;
      for (i = 0; i < NUM_REGS; i++) begin
         rd(REG_ADDR[i], d);
         chk("reset value", REG_RST[i], d);
         n = rnd();
         wr(REG_ADDR[i], n[7:0]);
         rd(REG_ADDR[i], d);
         chk("readback", n[7:0], d);
      end
      wr(16'h7f00, 8'h33);
      reg_debug <= 1'b0;
      wr(16'h7f00, 8'h5a);
      rd(16'h7f00, d);
      chk("hidden read", 8'h00, d);
      rd(16'h7f0b, d);
      chk("unmapped read", 8'h00, d);
      @(posedge sys_clk);
      reg_debug <= 1'b1;
      rd(16'h7f00, d);
      chk("hidden write", 8'h33, d);
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(16'h7f00, 8'h77);
      clk_en <= 1'b1;
      rd(16'h7f00, d);
      chk("frozen write", 8'h33, d);
      for (i = 0; i < 4; i++) wr(16'(MASK_ADDR + i), 8'hff);
      for (k = 0; k <= NUM_IRQ; k++) begin
         @(posedge sys_clk);
         if (k == NUM_IRQ) flash_write_protect_hit <= 1'b1;
         else lvl <= 25'(1) << k;
         @(posedge sys_clk);
         lvl <= '0;
         flash_write_protect_hit <= 1'b0;
         for (i = 0; i < 8 && irq_out !== 1'b1; i++) @(negedge sys_clk);
         chk("irq raised", !rsv(k), irq_out);
         if (i == 8 && !rsv(k)) finish_test();
         b = (k == NUM_IRQ) ? 24 : k;
         if (!rsv(k)) chk("vector", 24'h008008 + 24'(4 * b), vec_addr);
         rd(16'(STAT_ADDR + b / 8), d);
         chk("status bit", !rsv(k), d[b % 8]);
         repeat (3) @(negedge sys_clk);
         chk("irq cleared", 0, irq_out);
      end
      wr(16'h7fa5, 8'h00);
      @(posedge sys_clk);
      lvl <= 25'h0000400;
      @(posedge sys_clk);
      lvl <= '0;
      repeat (4) @(negedge sys_clk);
      chk("masked irq", 0, irq_out);
      rd(16'h7fa1, d);
      chk("masked status", 8'h04, d);
      wr(16'h7fa5, 8'hff);
      @(posedge sys_clk);
      trap_req <= 1'b1;
      @(posedge sys_clk);
      trap_req <= 1'b0;
      #1 chk("trap vector", 24'h008004, vec_addr);
      for (i = 0; i < 300; i++) begin
         n = (i < 5) ? corner[i] : rnd();
         @(posedge sys_clk);
         lvl <= n[24:0];
         flash_write_protect_hit <= n[28];
         @(posedge sys_clk);
         halt_mode <= n[25];
         active_halt_mode <= n[26];
         port_a_pin_one <= n[27];
         @(negedge sys_clk);
         e = exp_wake(src, halt_mode, active_halt_mode, port_a_pin_one);
         @(negedge sys_clk);
         chk("wake", e, wake_out);
      end
      wr(16'h7f08, 8'h5a);
      lvl <= '0;
      halt_mode <= 1'b0;
      active_halt_mode <= 1'b0;
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd(16'h7f08, d);
      chk("second reset", 8'h03, d);
      finish_test();
   end
endmodule
